/* File: rmt_mac.sv */
// Radio MAC core: addressing, delivery, held packets, channel check
// Assumes radio and host logic on the same clock; config ports are static
`timescale 1ns/1ps
`default_nettype none
`include "rmt_regs.svh"
module rmt_mac #(
  parameter int TICK_CYCLES = `RMT_TICK_CYCLES,
  parameter int BACKOFF_CYCLES = `RMT_BACKOFF_CYCLES,
  parameter int ACK_WAIT_CYCLES = `RMT_ACK_WAIT_CYCLES,
  parameter int PEND_SLOTS = `RMT_PEND_SLOTS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] short_source_address,
  input wire logic [31:0] destination_high,
  input wire logic [31:0] destination_low,
  input wire logic [31:0] serial_number_high,
  input wire logic [31:0] serial_number_low,
  input wire logic [15:0] cyclic_sleep_period,
  input wire logic [15:0] idle_time_before_sleep,
  input wire logic [7:0] clear_channel_threshold,
  input wire logic [2:0] backoff_exponent,
  input wire logic [1:0] mac_mode_select,
  input wire logic [2:0] retry_count,
  input wire logic [7:0] end_device_association_cfg,
  input wire logic force_poll_command,
  input wire logic is_coordinator,
  input wire logic beacon_timing,
  input wire logic beacon_tick,
  input wire logic associated,
  input wire logic cyclic_wake,
  input wire logic pin_wake,
  input wire logic sleep_cond,
  input wire logic cmd_seq_detect,
  input wire logic cmd_exit,
  input wire logic tx_req,
  output logic tx_ready,
  input wire logic rf_rx_valid,
  input wire rmt_pkg::rmt_hdr_s rx_hdr,
  input wire logic rf_poll_rx,
  output logic rx_accept,
  output logic rf_ack_send,
  input wire logic [7:0] ed_level,
  input wire logic ed_valid,
  output logic cca_req,
  output logic rf_tx_start,
  output var rmt_pkg::rmt_hdr_s tx_hdr,
  input wire logic rf_tx_done,
  input wire logic rf_ack_rx,
  output logic tx_done,
  output var rmt_pkg::rmt_stat_s tx_status,
  output logic poll_req,
  output var rmt_pkg::rmt_mode_e mode,
  output logic [PEND_SLOTS-1:0] pend_valid
);
  localparam int CW = 20;
  initial begin
    if (PEND_SLOTS < 1 || PEND_SLOTS > 2 || TICK_CYCLES < 1 || BACKOFF_CYCLES < 1
        || ACK_WAIT_CYCLES < 1 || TICK_CYCLES >= 2**CW || BACKOFF_CYCLES >= 2**CW
        || ACK_WAIT_CYCLES >= 2**CW)
      $error("rmt_mac: parameter out of range");
  end

  function automatic logic short_ok(input logic [15:0] a);
    return a < `RMT_ADDR_LIMIT;
  endfunction : short_ok

  // ----------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------
  logic assoc;
  logic next_assoc;
  logic [15:0] my_short;
  logic [63:0] serial;
  rmt_pkg::rmt_hdr_s new_hdr;
  assign my_short = assoc ? `RMT_ASSOC_SHORT : short_source_address;
  assign serial = {serial_number_high, serial_number_low};
  always_comb begin
    new_hdr = '0;
    new_hdr.src_long = !short_ok(my_short);
    new_hdr.src = new_hdr.src_long ? serial : {48'h0, my_short};
    new_hdr.bcast = destination_low == `RMT_BCAST_LOW && destination_high == `RMT_BCAST_HIGH;
    // destination field
    // Broadcast goes out as the short 0xFFFF address every receiver filters on
    new_hdr.dst_long = !new_hdr.bcast
      && !(destination_high == 32'h0 && destination_low < {16'h0, `RMT_ADDR_LIMIT});
    new_hdr.dst = new_hdr.dst_long ? {destination_high, destination_low}
                                   : {48'h0, destination_low[15:0]};
    new_hdr.ack_req = !new_hdr.bcast;
  end

  // ----------------------------------------------------------------
  // Receive filter
  // ----------------------------------------------------------------
  logic rx_bc;
  logic rx_hit;
  logic next_ack;
  assign rx_bc = !rx_hdr.dst_long && rx_hdr.dst[15:0] == `RMT_BCAST_SHORT;
  assign rx_hit = rx_bc
    || (!rx_hdr.dst_long && short_ok(my_short) && rx_hdr.dst[15:0] == my_short)
    || (rx_hdr.dst_long && rx_hdr.dst == serial);
  assign rx_accept = rf_rx_valid && rx_hit;
  assign next_ack = rx_accept && !rx_bc;

  // ----------------------------------------------------------------
  // Tick, random source, poll and misc flops
  // ----------------------------------------------------------------
  logic [CW-1:0] tick_cnt;
  logic [CW-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic next_poll;
  always_comb begin
    next_tick = tick_cnt == '0;
    next_tick_cnt = next_tick ? CW'(TICK_CYCLES - 1) : tick_cnt - 1'b1;
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    next_assoc = assoc || associated;
    next_poll = !is_coordinator && (cyclic_wake || force_poll_command
      || (pin_wake && end_device_association_cfg[`RMT_PIN_POLL_BIT]));
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      lfsr <= `RMT_LFSR_SEED;
      assoc <= 1'b0;
      poll_req <= 1'b0;
      rf_ack_send <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      lfsr <= next_lfsr;
      assoc <= next_assoc;
      poll_req <= next_poll;
      rf_ack_send <= next_ack;
    end
  end

  // ----------------------------------------------------------------
  // Direct window after end device traffic
  // ----------------------------------------------------------------
  logic aw_v;
  logic next_aw_v;
  logic aw_long;
  logic next_aw_long;
  logic [63:0] aw_addr;
  logic [63:0] next_aw_addr;
  logic [15:0] aw_cnt;
  logic [15:0] next_aw_cnt;
  logic aw_hit;
  assign aw_hit = aw_v && aw_addr == new_hdr.dst && aw_long == new_hdr.dst_long;
  always_comb begin
    next_aw_v = aw_v;
    next_aw_long = aw_long;
    next_aw_addr = aw_addr;
    next_aw_cnt = aw_cnt;
    if (aw_v && tick) begin
      if (aw_cnt == 16'h0) next_aw_v = 1'b0;
      else next_aw_cnt = aw_cnt - 16'h1;
    end
    if (is_coordinator && (rf_poll_rx || (rx_accept && !rx_bc))) begin
      next_aw_v = 1'b1;
      next_aw_long = rx_hdr.src_long;
      next_aw_addr = rx_hdr.src;
      next_aw_cnt = idle_time_before_sleep;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_v <= 1'b0;
      aw_long <= 1'b0;
      aw_addr <= '0;
      aw_cnt <= '0;
    end else begin
      aw_v <= next_aw_v;
      aw_long <= next_aw_long;
      aw_addr <= next_aw_addr;
      aw_cnt <= next_aw_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Held packet slots
  // ----------------------------------------------------------------
  logic [PEND_SLOTS-1:0] pg;
  logic [PEND_SLOTS-1:0] next_pg;
  logic [PEND_SLOTS-1:0] next_pv;
  logic [PEND_SLOTS-1:0] pl;
  logic [PEND_SLOTS-1:0] next_pl;
  logic [63:0] pd [PEND_SLOTS];
  logic [63:0] next_pd [PEND_SLOTS];
  logic [15:0] pa [PEND_SLOTS];
  logic [15:0] next_pa [PEND_SLOTS];
  logic need_ind;
  logic free_any;
  logic go_any;
  logic store;
  logic stored;
  logic age_step;
  logic [0:0] sel;
  rmt_pkg::rmt_tx_e tstate;
  // held only on coordinator with nonzero period
  assign need_ind = is_coordinator && cyclic_sleep_period != 16'h0
                    && !new_hdr.bcast && !aw_hit;
  assign free_any = !(&pend_valid);
  assign go_any = |pg;
  assign store = tx_req && tx_ready && need_ind;
  assign age_step = beacon_timing ? beacon_tick : tick;
  assign tx_ready = mode == rmt_pkg::M_TX && tstate == rmt_pkg::T_IDLE
                    && !go_any && (!need_ind || free_any);
  always_comb begin
    sel = '0;
    for (int i = PEND_SLOTS - 1; i >= 0; i--) begin
      if (pg[i]) sel = 1'(i);
    end
  end
  always_comb begin
    next_pv = pend_valid;
    next_pg = pg;
    next_pl = pl;
    next_pd = pd;
    next_pa = pa;
    stored = 1'b0;
    for (int i = 0; i < PEND_SLOTS; i++) begin
      if (pend_valid[i] && !pg[i] && age_step) begin
        if (pa[i] >= cyclic_sleep_period) next_pv[i] = 1'b0;
        else next_pa[i] = pa[i] + 16'h1;
      end
      if (pend_valid[i] && rf_poll_rx && rx_hdr.src == pd[i] && rx_hdr.src_long == pl[i])
        next_pg[i] = 1'b1;
      if (go_any && tstate == rmt_pkg::T_IDLE && sel == 1'(i)) begin
        next_pv[i] = 1'b0;
        next_pg[i] = 1'b0;
      end
      if (store && !stored && !pend_valid[i]) begin
        stored = 1'b1;
        next_pv[i] = 1'b1;
        next_pg[i] = 1'b0;
        next_pl[i] = new_hdr.dst_long;
        next_pd[i] = new_hdr.dst;
        next_pa[i] = 16'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_valid <= '0;
      pg <= '0;
      pl <= '0;
      for (int i = 0; i < PEND_SLOTS; i++) begin
        pd[i] <= '0;
        pa[i] <= '0;
      end
    end else begin
      pend_valid <= next_pv;
      pg <= next_pg;
      pl <= next_pl;
      pd <= next_pd;
      pa <= next_pa;
    end
  end

  // ----------------------------------------------------------------
  // Transmit engine
  // ----------------------------------------------------------------
  rmt_pkg::rmt_tx_e next_tstate;
  rmt_pkg::rmt_hdr_s next_tx_hdr;
  rmt_pkg::rmt_stat_s next_status;
  logic next_done;
  logic [1:0] cca_left;
  logic [1:0] next_cca_left;
  logic [1:0] ack_left;
  logic [1:0] next_ack_left;
  logic [7:0] bo_per;
  logic [7:0] next_bo_per;
  logic [CW-1:0] bo_cyc;
  logic [CW-1:0] next_bo_cyc;
  logic bo_load;
  logic [1:0] cca_init;
  assign rf_tx_start = tstate == rmt_pkg::T_SEND;
  assign cca_req = tstate == rmt_pkg::T_CCA;
  assign cca_init = (mac_mode_select == 2'h0 && (tx_hdr.bcast || retry_count == 3'h0))
                    ? `RMT_CCA_RETRIES : 2'h0;
  always_comb begin
    next_tstate = tstate;
    next_tx_hdr = tx_hdr;
    next_status = tx_status;
    next_done = 1'b0;
    next_cca_left = cca_left;
    next_ack_left = ack_left;
    next_bo_per = bo_per;
    next_bo_cyc = bo_cyc;
    bo_load = 1'b0;
    unique case (tstate)
      rmt_pkg::T_IDLE: begin
        if (go_any || (tx_req && tx_ready && !need_ind)) begin
          next_tx_hdr = new_hdr;
          if (go_any) begin
            next_tx_hdr.bcast = 1'b0;
            next_tx_hdr.ack_req = 1'b1;
            next_tx_hdr.dst_long = pl[sel];
            next_tx_hdr.dst = pd[sel];
          end
          next_cca_left = 2'h3;
          next_ack_left = next_tx_hdr.bcast ? 2'h0 : `RMT_ACK_RETRIES;
          bo_load = 1'b1;
          next_tstate = rmt_pkg::T_BACKOFF;
        end
      end
      rmt_pkg::T_BACKOFF: begin
        if (cca_left == 2'h3) next_cca_left = cca_init;
        if (bo_cyc != '0) next_bo_cyc = bo_cyc - 1'b1;
        else if (bo_per == 8'h0) next_tstate = rmt_pkg::T_CCA;
        else begin
          next_bo_per = bo_per - 8'h1;
          next_bo_cyc = CW'(BACKOFF_CYCLES - 1);
        end
      end
      rmt_pkg::T_CCA: begin
        if (ed_valid && ed_level > clear_channel_threshold) begin
          if (cca_left != 2'h0) begin
            next_cca_left = cca_left - 2'h1;
            bo_load = 1'b1;
            next_tstate = rmt_pkg::T_BACKOFF;
          end else begin
            next_done = 1'b1;
            next_status = '{ok: 1'b0, ack_fail: 1'b0, cca_fail: 1'b1};
            next_tstate = rmt_pkg::T_IDLE;
          end
        end else if (ed_valid) next_tstate = rmt_pkg::T_SEND;
      end
      rmt_pkg::T_SEND: next_tstate = rmt_pkg::T_WAIT;
      rmt_pkg::T_WAIT: begin
        if (rf_tx_done && tx_hdr.bcast) begin
          next_done = 1'b1;
          next_status = '{ok: 1'b1, ack_fail: 1'b0, cca_fail: 1'b0};
          next_tstate = rmt_pkg::T_IDLE;
        end else if (rf_tx_done) begin
          next_bo_cyc = CW'(ACK_WAIT_CYCLES - 1);
          next_tstate = rmt_pkg::T_ACK;
        end
      end
      rmt_pkg::T_ACK: begin
        if (rf_ack_rx) begin
          next_done = 1'b1;
          next_status = '{ok: 1'b1, ack_fail: 1'b0, cca_fail: 1'b0};
          next_tstate = rmt_pkg::T_IDLE;
        end else if (bo_cyc != '0) next_bo_cyc = bo_cyc - 1'b1;
        else if (ack_left != 2'h0) begin
          next_ack_left = ack_left - 2'h1;
          next_cca_left = 2'h3;
          bo_load = 1'b1;
          next_tstate = rmt_pkg::T_BACKOFF;
        end else begin
          next_done = 1'b1;
          next_status = '{ok: 1'b0, ack_fail: 1'b1, cca_fail: 1'b0};
          next_tstate = rmt_pkg::T_IDLE;
        end
      end
    endcase
    // random backoff, none at exponent zero
    if (bo_load) begin
      next_bo_per = lfsr[7:0] & ((8'h01 << backoff_exponent) - 8'h01);
      next_bo_cyc = '0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tstate <= rmt_pkg::T_IDLE;
      tx_hdr <= '0;
      tx_status <= '0;
      tx_done <= 1'b0;
      cca_left <= '0;
      ack_left <= '0;
      bo_per <= '0;
      bo_cyc <= '0;
    end else begin
      tstate <= next_tstate;
      tx_hdr <= next_tx_hdr;
      tx_status <= next_status;
      tx_done <= next_done;
      cca_left <= next_cca_left;
      ack_left <= next_ack_left;
      bo_per <= next_bo_per;
      bo_cyc <= next_bo_cyc;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  rmt_pkg::rmt_mode_e next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      rmt_pkg::M_IDLE: begin
        if (tx_req || go_any) next_mode = rmt_pkg::M_TX;
        else if (rf_rx_valid) next_mode = rmt_pkg::M_RX;
        else if (cmd_seq_detect) next_mode = rmt_pkg::M_CMD;
        else if (sleep_cond) next_mode = rmt_pkg::M_SLEEP;
      end
      rmt_pkg::M_TX: begin
        if (tstate == rmt_pkg::T_IDLE && !tx_req && !go_any) next_mode = rmt_pkg::M_IDLE;
      end
      rmt_pkg::M_RX: next_mode = rmt_pkg::M_IDLE;
      rmt_pkg::M_SLEEP: if (!sleep_cond) next_mode = rmt_pkg::M_IDLE;
      rmt_pkg::M_CMD: if (cmd_exit) next_mode = rmt_pkg::M_IDLE;
      default: next_mode = rmt_pkg::M_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode <= rmt_pkg::M_IDLE;
    else mode <= next_mode;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] sends;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sends <= '0;
    else if (tstate == rmt_pkg::T_IDLE) sends <= '0;
    else if (rf_tx_start) sends <= sends + 3'h1;
  end
  chk_send_count: assert property (@(posedge clk) disable iff (!rst_n)
    sends <= 3'h4) else $error("more than four sends of one packet");
  chk_bcast_no_ack: assert property (@(posedge clk) disable iff (!rst_n)
    tstate == rmt_pkg::T_WAIT && tx_hdr.bcast && rf_tx_done |=> tstate == rmt_pkg::T_IDLE && tx_done)
    else $error("broadcast waited for ack");
  chk_short_src: assert property (@(posedge clk) disable iff (!rst_n)
    rf_tx_start && !assoc && short_source_address < 16'hFFFE |-> !tx_hdr.src_long)
    else $error("short source not used");
  chk_store_coord: assert property (@(posedge clk) disable iff (!rst_n)
    store |-> is_coordinator && cyclic_sleep_period != 16'h0) else $error("bad hold");
  chk_rx_bcast: assert property (@(posedge clk) disable iff (!rst_n)
    rf_rx_valid && !rx_hdr.dst_long && rx_hdr.dst[15:0] == 16'hFFFF |-> rx_accept ##1 !rf_ack_send)
    else $error("broadcast handling wrong");
  chk_busy_channel: assert property (@(posedge clk) disable iff (!rst_n)
    cca_req && ed_valid && ed_level > clear_channel_threshold |=> !rf_tx_start)
    else $error("sent on busy channel");
  chk_ack_fail: assert property (@(posedge clk) disable iff (!rst_n)
    tx_done && tx_status.ack_fail |-> $past(tstate) == rmt_pkg::T_ACK && $past(ack_left) == 2'h0)
    else $error("ack failure without exhausted retries");
  chk_idle_tx: assert property (@(posedge clk) disable iff (!rst_n)
    mode == rmt_pkg::M_IDLE && tx_req |=> mode == rmt_pkg::M_TX) else $error("no transmit mode");
  chk_poll: assert property (@(posedge clk) disable iff (!rst_n)
    !is_coordinator && force_poll_command |=> poll_req) else $error("force poll missed");
endmodule : rmt_mac
`default_nettype wire

/* File: rmt_mac_tb.sv */
// Self-checking bench of the radio MAC core
// Assumes rmt_peer and shortened timing parameters
`timescale 1ns/1ps
`default_nettype none
module rmt_mac_tb;
  logic clk, rst_n, tx_req, rf_rx_valid, busy, ack_on, ack_pend;
  logic [15:0] my_short;
  logic [15:0] lim [3] = '{16'hFFFD, 16'hFFFE, 16'hFFFF};
  logic [31:0] dst_hi, dst_lo, sn_hi, sn_lo;
  logic [2:0] be, sends;
  rmt_pkg::rmt_hdr_s rx_hdr, tx_hdr;
  rmt_pkg::rmt_stat_s tx_status;
  logic tx_ready, rx_accept, rf_ack_send, cca_req, rf_tx_start, tx_done;
  logic [7:0] ed_level;
  logic ed_valid, rf_tx_done, rf_ack_rx;
  logic [9:0] txq [$];
  logic [1:0] rxq [$];
  logic [1:0] rx_exp;
  int n_mismatch, compares, n_done, seed;
  logic [15:0] csp, itb;
  logic [7:0] cct, eda;
  logic [1:0] mms;
  logic [2:0] rrc;
  logic fpc, coord, assoc_p, cwake, pwake, poll_rx, poll_req;

  rmt_mac #(.TICK_CYCLES(20), .BACKOFF_CYCLES(4), .ACK_WAIT_CYCLES(10)) uut (
    .clk(clk), .rst_n(rst_n), .short_source_address(my_short),
    .destination_high(dst_hi), .destination_low(dst_lo),
    .serial_number_high(sn_hi), .serial_number_low(sn_lo),
    .cyclic_sleep_period(csp), .idle_time_before_sleep(itb),
    .clear_channel_threshold(cct), .backoff_exponent(be),
    .mac_mode_select(mms), .retry_count(rrc), .end_device_association_cfg(eda),
    .force_poll_command(fpc), .is_coordinator(coord), .beacon_timing(1'b0),
    .beacon_tick(1'b0), .associated(assoc_p), .cyclic_wake(cwake), .pin_wake(pwake),
    .sleep_cond(1'b0), .cmd_seq_detect(1'b0), .cmd_exit(1'b0),
    .tx_req(tx_req), .tx_ready(tx_ready), .rf_rx_valid(rf_rx_valid),
    .rx_hdr(rx_hdr), .rf_poll_rx(poll_rx), .rx_accept(rx_accept),
    .rf_ack_send(rf_ack_send), .ed_level(ed_level), .ed_valid(ed_valid),
    .cca_req(cca_req), .rf_tx_start(rf_tx_start), .tx_hdr(tx_hdr),
    .rf_tx_done(rf_tx_done), .rf_ack_rx(rf_ack_rx), .tx_done(tx_done),
    .tx_status(tx_status), .poll_req(poll_req), .mode(), .pend_valid()
  );
  rmt_peer peer (
    .clk(clk), .rst_n(rst_n), .cca_req(cca_req), .rf_tx_start(rf_tx_start),
    .ack_req(tx_hdr.ack_req), .busy(busy), .ack_on(ack_on),
    .ed_level(ed_level), .ed_valid(ed_valid), .rf_tx_done(rf_tx_done),
    .rf_ack_rx(rf_ack_rx)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cmp_tx(input logic [9:0] e, input logic [9:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value tx result exp %h got %h", e, s);
    end
  endtask : cmp_tx

  task automatic cmp_bit(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %b got %b", n, e, s);
    end
  endtask : cmp_bit

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Expect {src_long, dst_long, bcast, ack_req, status, sends}
  task automatic send(input logic [9:0] e);
    int k;
    txq.push_back(e);
    k = n_done;
    be = 3'($random(seed) & 3);
    tx_req = 1'b1;
    @(negedge clk);
    while (!tx_ready) @(negedge clk);
    @(negedge clk) tx_req = 1'b0;
    while (n_done == k) @(negedge clk);
    $display("test done tx %0d", n_done);
  endtask : send

  task automatic recv(input logic [15:0] d, input logic bc, input logic [1:0] e);
    rxq.push_back(e);
    rx_hdr = '0;
    rx_hdr.dst = {48'h0, d};
    rx_hdr.bcast = bc;
    rx_hdr.ack_req = ~bc;
    rf_rx_valid = 1'b1;
    @(negedge clk) rf_rx_valid = 1'b0;
    repeat (2) @(negedge clk);
    $display("test done rx");
  endtask : recv

  // One-cycle wake or poll pulse, then look at the registered poll request
  task automatic poll(input logic f, input logic c, input logic p, input logic e);
    {fpc, cwake, pwake} = {f, c, p};
    @(negedge clk) {fpc, cwake, pwake} = 3'h0;
    cmp_bit("poll_req", e, poll_req);
    $display("test done poll");
  endtask : poll

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (ack_pend) cmp_bit("rf_ack_send", rx_exp[0], rf_ack_send);
    ack_pend = 1'b0;
    if (rf_rx_valid) begin
      rx_exp = rxq.pop_front();
      cmp_bit("rx_accept", rx_exp[1], rx_accept);
      ack_pend = 1'b1;
    end
    if (tx_done) begin
      cmp_tx(txq.pop_front(), {tx_hdr[131], tx_hdr[66], tx_hdr[1:0], tx_status, sends});
      sends = 3'h0;
      n_done++;
    end
    if (rf_tx_start) sends = sends + 3'h1;
  end

  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    seed = 32'h9d71;
    {rst_n, tx_req, rf_rx_valid, busy, ack_pend, sends, be} = '0;
    ack_on = 1'b1;
    rx_hdr = '0;
    {csp, itb, eda, mms, rrc} = '0;
    {fpc, coord, assoc_p, cwake, pwake, poll_rx} = '0;
    cct = 8'h80;
    my_short = 16'($random(seed) & 32'h7FFF);
    sn_hi = $random(seed);
    sn_lo = $random(seed);
    dst_hi = 32'h00000000;
    dst_lo = $random(seed) & 32'h00007FFF;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    send({4'h1, 3'h4, 3'h1});
    ack_on = 1'b0;
    send({4'h1, 3'h2, 3'h4});
    ack_on = 1'b1;
    dst_lo = 32'h0000FFFF;
    send({4'h2, 3'h4, 3'h1});
    busy = 1'b1;
    send({4'h2, 3'h1, 3'h0});
    busy = 1'b0;
    dst_hi = $random(seed) | 32'h1;
    foreach (lim[i]) begin
      my_short = lim[i];
      send({i != 0, 3'h5, 3'h4, 3'h1});
    end
    my_short = 16'($random(seed) & 32'h7FFF);
    recv(my_short, 1'b0, 2'h3);
    recv(my_short ^ 16'h0001, 1'b0, 2'h0);
    recv(16'hFFFF, 1'b1, 2'h2);
    poll(1'b1, 1'b0, 1'b0, 1'b1);
    poll(1'b0, 1'b1, 1'b0, 1'b1);
    poll(1'b0, 1'b0, 1'b1, 1'b0);
    eda = 8'h08;
    poll(1'b0, 1'b0, 1'b1, 1'b1);
    assoc_p = 1'b1;
    @(negedge clk) assoc_p = 1'b0;
    send({4'hD, 3'h4, 3'h1});
    finish_test();
  end
endmodule : rmt_mac_tb
`default_nettype wire

/* File: rmt_peer.sv */
// Radio peer model: energy answer, send done, ack
// Assumes the core on the same clock
`timescale 1ns/1ps
`default_nettype none
module rmt_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cca_req,
  input wire logic rf_tx_start,
  input wire logic ack_req,
  input wire logic busy,
  input wire logic ack_on,
  output logic [7:0] ed_level,
  output logic ed_valid,
  output logic rf_tx_done,
  output logic rf_ack_rx
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ed_level <= 8'h00;
      ed_valid <= 1'b0;
      rf_tx_done <= 1'b0;
      rf_ack_rx <= 1'b0;
    end else begin
      ed_valid <= cca_req & ~ed_valid;
      // Level is garbage outside the answer
      ed_level <= (cca_req & ~ed_valid) ? {8{busy}} : ~ed_level;
      rf_tx_done <= rf_tx_start;
      rf_ack_rx <= rf_tx_done & ack_req & ack_on;
    end
  end
endmodule : rmt_peer
`default_nettype wire

/* File: rmt_pkg.sv */
// Types shared by the radio MAC core and its testbench
// Assumes the constants header is compiled alongside
package rmt_pkg;
  typedef struct packed {
    logic src_long;
    logic [63:0] src;
    logic dst_long;
    logic [63:0] dst;
    logic bcast;
    logic ack_req;
  } rmt_hdr_s;
  typedef struct packed {
    logic ok;
    logic ack_fail;
    logic cca_fail;
  } rmt_stat_s;
  typedef enum logic [2:0] {M_IDLE, M_TX, M_RX, M_SLEEP, M_CMD} rmt_mode_e;
  typedef enum logic [2:0] {T_IDLE, T_BACKOFF, T_CCA, T_SEND, T_WAIT, T_ACK} rmt_tx_e;
endpackage : rmt_pkg

/* File: rmt_regs.svh */
// Constants of the radio MAC transmit, addressing and retry core
// Assumes a 20 MHz clock; included by the core before the package types
`ifndef RMT_REGS_SVH
`define RMT_REGS_SVH
`define RMT_CLK_PERIOD_NS 50
`define RMT_TICK_TIME_US 1000
`define RMT_TICK_CYCLES (`RMT_TICK_TIME_US * 1000 / `RMT_CLK_PERIOD_NS)
`define RMT_BACKOFF_TIME_US 320
`define RMT_BACKOFF_CYCLES (`RMT_BACKOFF_TIME_US * 1000 / `RMT_CLK_PERIOD_NS)
`define RMT_ACK_WAIT_TIME_US 864
`define RMT_ACK_WAIT_CYCLES (`RMT_ACK_WAIT_TIME_US * 1000 / `RMT_CLK_PERIOD_NS)
`define RMT_ACK_RETRIES 2'h3
`define RMT_CCA_RETRIES 2'h2
`define RMT_ADDR_LIMIT 16'hFFFE
`define RMT_BCAST_SHORT 16'hFFFF
`define RMT_BCAST_LOW 32'h0000FFFF
`define RMT_BCAST_HIGH 32'h00000000
`define RMT_ASSOC_SHORT 16'hFFFE
`define RMT_PIN_POLL_BIT 3
`define RMT_PEND_SLOTS 2
`define RMT_LFSR_SEED 16'hACE1
`endif
